// ==== src/sec_defs.vh ====
// constants for the serial nvm controller: opcodes, frame layout, timing
// assumes a single 20 MHz system clock
`ifndef SEC_DEFS_VH
`define SEC_DEFS_VH

// host opcode field encodings
`define SEC_OP_READ 3'h0
`define SEC_OP_WR_DISABLE 3'h1
`define SEC_OP_WR_ENABLE 3'h2
`define SEC_OP_WRITE 3'h3
`define SEC_OP_WRITE_ALL 3'h4
`define SEC_OP_ERASE_ALL 3'h5
`define SEC_OP_ERASE 3'h6
`define SEC_OP_RELOAD 3'h7

// serial opcodes and extended selectors (top two location bits)
`define SEC_SOP_EXT 2'h0
`define SEC_SOP_WRITE 2'h1
`define SEC_SOP_READ 2'h2
`define SEC_SOP_ERASE 2'h3
`define SEC_EXT_WR_DISABLE 2'h0
`define SEC_EXT_WRITE_ALL 2'h1
`define SEC_EXT_ERASE_ALL 2'h2
`define SEC_EXT_WR_ENABLE 2'h3

// frame lengths in serial clocks
`define SEC_FRAME_SHORT 5'h0A
`define SEC_FRAME_LONG 5'h12
`define SEC_HDR_BITS 5'h0A

// auto-load
`define SEC_SIG_VALUE 8'hA5
`define SEC_SIG_ADDR 7'h00
`define SEC_MAC_LAST 7'h06

// reset values
`define SEC_RST_OPCODE 3'h0
`define SEC_RST_LOCATION 7'h00
`define SEC_RST_DATA 8'h00
`define SEC_RST_STATION 48'h0000_0000_0000

// timing
`define SEC_SYS_CLK_NS 50
`define SEC_SCLK_NS 400
`define SEC_TIMEOUT_MS 30
`define SEC_SCLK_HALF ((`SEC_SCLK_NS + 2 * `SEC_SYS_CLK_NS - 1) / (2 * `SEC_SYS_CLK_NS))
`define SEC_TIMEOUT_CYC (`SEC_TIMEOUT_MS * 1000000 / `SEC_SYS_CLK_NS)

`endif

// ==== src/sec_clkdiv.v ====
// divider producing one-cycle ticks at twice the serial clock rate
// assumes clk_i is the system clock; en_i from same domain
`timescale 1ns/1ps
`default_nettype none
module sec_clkdiv #(
	parameter HALF = 4
) (
	input wire clk_i,
	input wire resetn_i,
	input wire en_i,
	output reg tick_o
);
	localparam integer LAST_I = HALF - 1;
	localparam [7:0] LAST = LAST_I[7:0];
	reg [7:0] cnt_q;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= 8'h00;
			tick_o <= 1'b0;
		end else if (!en_i) begin
			cnt_q <= 8'h00;
			tick_o <= 1'b0;
		end else if (cnt_q == LAST) begin
			cnt_q <= 8'h00;
			tick_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 8'h01;
			tick_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== src/sec_shifter.v ====
// serial frame engine: shifts a frame msb first, samples returning bits
// assumes tick_i comes from sec_clkdiv and din_i is already synchronised
`timescale 1ns/1ps
`default_nettype none
module sec_shifter (
	input wire clk_i,
	input wire resetn_i,
	input wire tick_i,
	input wire start_i,
	input wire [17:0] frame_i,
	input wire [4:0] nbits_i,
	input wire [4:0] drive_bits_i,
	input wire din_i,
	output wire run_o,
	output wire dout_o,
	output reg sclk_o,
	output reg oe_o,
	output reg done_o,
	output reg [7:0] rdata_o
);
	reg run_q;
	reg phase_q;
	reg [4:0] cnt_q;
	reg [17:0] sr_q;
	reg [4:0] nbits_q;
	reg [4:0] drive_q;

	assign run_o = run_q;
	assign dout_o = sr_q[17];

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			run_q <= 1'b0;
			phase_q <= 1'b0;
			cnt_q <= 5'h00;
			sr_q <= 18'h00000;
			nbits_q <= 5'h00;
			drive_q <= 5'h00;
			sclk_o <= 1'b0;
			oe_o <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			done_o <= 1'b0;
			if (!run_q) begin
				if (start_i) begin
					run_q <= 1'b1;
					phase_q <= 1'b0;
					cnt_q <= 5'h00;
					sr_q <= frame_i;
					nbits_q <= nbits_i;
					drive_q <= drive_bits_i;
					oe_o <= 1'b1;
				end
			end else if (tick_i) begin
				if (!phase_q) begin
					sclk_o <= 1'b1;
					phase_q <= 1'b1;
					cnt_q <= cnt_q + 5'h01;
				end else begin
					// memory updates its output after the rising edge
					sclk_o <= 1'b0;
					phase_q <= 1'b0;
					rdata_o <= {rdata_o[6:0], din_i};
					if (cnt_q == nbits_q) begin
						run_q <= 1'b0;
						oe_o <= 1'b0;
						done_o <= 1'b1;
					end else begin
						sr_q <= {sr_q[16:0], 1'b0};
						oe_o <= (cnt_q < drive_q);
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== src/sec_ctrl.v ====
// serial nvm controller: station address auto-load and host commands
// assumes a 20 MHz system clock; pin inputs are asynchronous to it
`timescale 1ns/1ps
`default_nettype none
`include "sec_defs.vh"

// Contract
// R1: after any reset read location 00h; memory valid only if it holds A5h.
// R2: on valid signature load next six bytes into station address, byte 0 first.
// R3: set address-loaded flag once all six station bytes are stored.
// R4: without signature stop init, load nothing, leave address to host.
// R5: host reload repeats check and load; flag set only on success.
// R6: host operations refused until reset-time load or attempt finishes.
// R7: host loads data register before opcode and location for writes.
// R8: host starts an operation by writing busy; controller clears busy at end.
// R9: read command places fetched byte in data register before busy clears.
// R10: host waits for busy low before writing the command register again.
// R11: no ready answer within 30 ms abandons operation and sets timeout flag.
// R12: host issues erase/write enable before any erase or write.
// R13: erase-location sends a serial erase of the addressed byte.
// R14: erase-all sends a bulk erase of every location.
// R15: after disable command the memory ignores erase and write until enabled.
// R16: write-location shifts the data register byte to the addressed location.
// R17: write-all shifts the data register byte for every location.
// R18: 10 serial clocks for erase, erase-all, enable, disable; 18 for others.
// R19: memory is 128 locations of 8 bits selected by the location field.
// R20: with interface disabled, data and clock pins carry general or monitor signals.
// R21: frame is start bit, 2-bit opcode, 7-bit address, data, msb first, select high.
module sec_ctrl #(
	parameter TIMEOUT_CYCLES = `SEC_TIMEOUT_CYC,
	parameter SCLK_HALF = `SEC_SCLK_HALF
) (
	input wire clk_i,
	input wire resetn_i,
	input wire soft_reset_i,
	input wire host_cmd_wr_i,
	input wire host_busy_i,
	input wire [2:0] host_opcode_i,
	input wire [6:0] host_location_i,
	input wire host_data_wr_i,
	input wire [7:0] host_data_i,
	input wire host_station_wr_i,
	input wire [47:0] host_station_i,
	input wire nvm_if_disable_i,
	input wire mii_monitor_sel_i,
	input wire gp_data_i,
	input wire gp_clock_i,
	input wire mii_mon_data_i,
	input wire mii_mon_clock_i,
	input wire nvm_serial_data_pin_i,
	output reg nvm_serial_data_pin_o,
	output reg nvm_serial_data_pin_oe_o,
	output reg nvm_clock_pin_o,
	output reg nvm_chip_select_o,
	output wire nvm_busy_flag_o,
	output reg nvm_timeout_flag_o,
	output reg station_addr_loaded_flag_o,
	output reg [2:0] nvm_opcode_field_o,
	output reg [6:0] nvm_location_field_o,
	output reg [7:0] nvm_data_reg_o,
	output wire [31:0] station_addr_low_reg_o,
	output wire [15:0] station_addr_high_reg_o
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_SIG = 3'h1;
	localparam [2:0] S_LOAD = 3'h2;
	localparam [2:0] S_CMD = 3'h3;
	localparam [2:0] S_GAP = 3'h4;
	localparam [2:0] S_POLL = 3'h5;
	localparam integer TO_LAST_I = TIMEOUT_CYCLES - 1;
	localparam [19:0] TO_LAST = TO_LAST_I[19:0];

	function [17:0] sec_frame;
		input [1:0] sop;
		input [6:0] addr;
		input [7:0] dat;
		begin
			sec_frame = {1'b1, sop, addr, dat};
		end
	endfunction

	reg [2:0] state_q;
	reg busy_q;
	reg launched_q;
	reg soft_pend_q;
	reg [6:0] idx_q;
	reg [47:0] station_q;
	reg [19:0] to_q;
	reg poll_cs_q;
	reg din_meta_q;
	reg din_sync_q;

	wire tick;
	wire sh_run;
	wire sh_dout;
	wire sh_sclk;
	wire sh_oe;
	wire sh_done;
	wire [7:0] sh_rdata;
	wire framing;
	wire op_waits;
	wire host_go;

	reg [1:0] sop;
	reg [6:0] saddr;
	reg [4:0] nbits;
	reg [4:0] drive;

	assign nvm_busy_flag_o = busy_q;
	assign station_addr_low_reg_o = station_q[31:0];
	assign station_addr_high_reg_o = station_q[47:32];
	assign framing = (state_q == S_SIG) || (state_q == S_LOAD) || (state_q == S_CMD);
	assign op_waits = (nvm_opcode_field_o == `SEC_OP_WRITE) || (nvm_opcode_field_o == `SEC_OP_WRITE_ALL) ||
		(nvm_opcode_field_o == `SEC_OP_ERASE) || (nvm_opcode_field_o == `SEC_OP_ERASE_ALL);
	assign host_go = host_cmd_wr_i && host_busy_i && !busy_q;

	// ------------------------------------------------------------
	// pin input synchroniser
	// ------------------------------------------------------------
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			din_meta_q <= 1'b0;
			din_sync_q <= 1'b0;
		end else begin
			din_meta_q <= nvm_serial_data_pin_i;
			din_sync_q <= din_meta_q;
		end
	end

	// ------------------------------------------------------------
	// frame selection
	// ------------------------------------------------------------
	always @* begin
		sop = `SEC_SOP_READ;
		saddr = idx_q;
		nbits = `SEC_FRAME_LONG;
		drive = `SEC_HDR_BITS;
		if (state_q == S_CMD) begin
			saddr = nvm_location_field_o; // R19
			case (nvm_opcode_field_o)
				`SEC_OP_READ: begin
					sop = `SEC_SOP_READ;
				end
				`SEC_OP_WRITE: begin
					sop = `SEC_SOP_WRITE; // R16
					drive = `SEC_FRAME_LONG;
				end
				`SEC_OP_ERASE: begin
					sop = `SEC_SOP_ERASE; // R13
					nbits = `SEC_FRAME_SHORT; // R18
				end
				`SEC_OP_ERASE_ALL: begin
					sop = `SEC_SOP_EXT; // R14
					saddr = {`SEC_EXT_ERASE_ALL, 5'h00};
					nbits = `SEC_FRAME_SHORT; // R18
				end
				`SEC_OP_WRITE_ALL: begin
					sop = `SEC_SOP_EXT; // R17
					saddr = {`SEC_EXT_WRITE_ALL, 5'h00};
					drive = `SEC_FRAME_LONG;
				end
				`SEC_OP_WR_ENABLE: begin
					sop = `SEC_SOP_EXT;
					saddr = {`SEC_EXT_WR_ENABLE, 5'h00};
					nbits = `SEC_FRAME_SHORT; // R18
				end
				`SEC_OP_WR_DISABLE: begin
					sop = `SEC_SOP_EXT;
					saddr = {`SEC_EXT_WR_DISABLE, 5'h00};
					nbits = `SEC_FRAME_SHORT; // R18
				end
				default: begin
					sop = `SEC_SOP_READ;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// serial engine
	// ------------------------------------------------------------
	sec_clkdiv #(
		.HALF(SCLK_HALF)
	) u_div (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.en_i(state_q != S_IDLE),
		.tick_o(tick)
	);

	sec_shifter u_shift (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.tick_i(tick),
		.start_i(framing && !launched_q),
		.frame_i(sec_frame(sop, saddr, nvm_data_reg_o)), // R21
		.nbits_i(nbits),
		.drive_bits_i(drive),
		.din_i(din_sync_q),
		.run_o(sh_run),
		.dout_o(sh_dout),
		.sclk_o(sh_sclk),
		.oe_o(sh_oe),
		.done_o(sh_done),
		.rdata_o(sh_rdata)
	);

	// ------------------------------------------------------------
	// control sequencer
	// ------------------------------------------------------------
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= S_SIG; // R1
			busy_q <= 1'b1; // R6
			launched_q <= 1'b0;
			soft_pend_q <= 1'b0;
			idx_q <= `SEC_SIG_ADDR;
			station_q <= `SEC_RST_STATION;
			to_q <= 20'h00000;
			poll_cs_q <= 1'b0;
			nvm_timeout_flag_o <= 1'b0;
			station_addr_loaded_flag_o <= 1'b0;
			nvm_opcode_field_o <= `SEC_RST_OPCODE;
			nvm_location_field_o <= `SEC_RST_LOCATION;
			nvm_data_reg_o <= `SEC_RST_DATA;
		end else begin
			if (framing && !launched_q) begin
				launched_q <= 1'b1;
			end
			case (state_q)
				S_IDLE: begin
					if (soft_pend_q) begin
						soft_pend_q <= 1'b0;
						busy_q <= 1'b1;
						idx_q <= `SEC_SIG_ADDR;
						station_addr_loaded_flag_o <= 1'b0;
						state_q <= S_SIG;
					end else begin
						if (host_cmd_wr_i && !busy_q) begin
							nvm_opcode_field_o <= host_opcode_i; // R7
							nvm_location_field_o <= host_location_i;
						end
						if (host_data_wr_i && !busy_q) begin
							nvm_data_reg_o <= host_data_i; // R7
						end
						if (host_station_wr_i && !busy_q) begin
							station_q <= host_station_i; // R4
						end
						if (host_go) begin
							busy_q <= 1'b1; // R8
							nvm_timeout_flag_o <= 1'b0;
							if (host_opcode_i == `SEC_OP_RELOAD) begin
								idx_q <= `SEC_SIG_ADDR; // R5
								station_addr_loaded_flag_o <= 1'b0;
								state_q <= S_SIG;
							end else begin
								state_q <= S_CMD;
							end
						end
					end
				end
				S_SIG: begin
					if (sh_done) begin
						launched_q <= 1'b0;
						if (sh_rdata == `SEC_SIG_VALUE) begin
							idx_q <= idx_q + 7'h01; // R1
							state_q <= S_LOAD;
						end else begin
							busy_q <= 1'b0; // R4
							state_q <= S_IDLE;
						end
					end
				end
				S_LOAD: begin
					if (sh_done) begin
						launched_q <= 1'b0;
						station_q[{idx_q[2:0] - 3'h1, 3'h0} +: 8] <= sh_rdata; // R2
						if (idx_q == `SEC_MAC_LAST) begin
							station_addr_loaded_flag_o <= 1'b1; // R3
							busy_q <= 1'b0; // R6
							state_q <= S_IDLE;
						end else begin
							idx_q <= idx_q + 7'h01;
						end
					end
				end
				S_CMD: begin
					if (sh_done) begin
						launched_q <= 1'b0;
						if (nvm_opcode_field_o == `SEC_OP_READ) begin
							nvm_data_reg_o <= sh_rdata; // R9
						end
						if (op_waits) begin
							to_q <= 20'h00000;
							state_q <= S_GAP;
						end else begin
							busy_q <= 1'b0; // R8
							state_q <= S_IDLE;
						end
					end
				end
				S_GAP: begin
					// select low for one tick before polling ready
					to_q <= to_q + 20'h00001;
					if (tick) begin
						poll_cs_q <= 1'b1;
						state_q <= S_POLL;
					end
				end
				S_POLL: begin
					to_q <= to_q + 20'h00001;
					// a tick lands only after the line behind the new select has passed the synchroniser
					if (tick && din_sync_q) begin
						poll_cs_q <= 1'b0;
						busy_q <= 1'b0; // R8
						state_q <= S_IDLE;
					end else if (to_q >= TO_LAST) begin
						poll_cs_q <= 1'b0;
						nvm_timeout_flag_o <= 1'b1; // R11
						busy_q <= 1'b0;
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
					busy_q <= 1'b0;
				end
			endcase
			if (soft_reset_i) begin
				soft_pend_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// pin outputs
	// ------------------------------------------------------------
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			nvm_serial_data_pin_o <= 1'b0;
			nvm_serial_data_pin_oe_o <= 1'b0;
			nvm_clock_pin_o <= 1'b0;
			nvm_chip_select_o <= 1'b0;
		end else if (nvm_if_disable_i) begin
			nvm_serial_data_pin_o <= mii_monitor_sel_i ? mii_mon_data_i : gp_data_i; // R20
			nvm_serial_data_pin_oe_o <= 1'b1;
			nvm_clock_pin_o <= mii_monitor_sel_i ? mii_mon_clock_i : gp_clock_i; // R20
			nvm_chip_select_o <= 1'b0;
		end else begin
			nvm_serial_data_pin_o <= sh_dout;
			nvm_serial_data_pin_oe_o <= sh_oe;
			nvm_clock_pin_o <= sh_sclk;
			nvm_chip_select_o <= sh_run || poll_cs_q; // R21
		end
	end
endmodule
`default_nettype wire

// ==== dv/sec_nvm_model.sv ====
// serial memory model: 128 x 8, three-wire frames, ready status on poll
// assumes the controller's select, clock and resolved data line
`timescale 1ns/1ps
`default_nettype none
module sec_nvm_model (
	input wire logic clk_i,
	input wire logic cs_i,
	input wire logic sclk_i,
	input wire logic di_i,
	input wire logic stall_i,
	input wire logic [7:0] dly_i,
	output logic do_o
);
	logic [7:0] mem [128];
	logic [17:0] sh = 0;
	logic [4:0] n = 0;
	logic [1:0] op = 0;
	logic [6:0] a = 0;
	logic [7:0] cnt = 0;
	logic wen = 0, pend = 0, rd = 0, v = 0, tog = 0, g;
	// a released line shows a changing pattern
	assign do_o = (pend && cs_i) ? (cnt == 0 && !stall_i) : rd ? v : tog;
	always @(posedge clk_i) begin
		tog <= ~tog;
		if (pend && cs_i && cnt != 0)
			cnt <= cnt - 8'h01;
	end
	always @(posedge sclk_i) begin
		if (cs_i) begin
			sh = {sh[16:0], di_i};
			n = n + 5'h01;
			if (n == 5'h0A) begin
				op = sh[8:7];
				a = sh[6:0];
			end
			if (n > 5'h0A && op == 2'h2) begin
				rd = 1;
				v = mem[a][18 - n];
			end
		end
	end
	always @(negedge cs_i) begin
		rd = 0;
		pend = 0;
		g = op == 2'h0 && (a[6:5] == 2'h1 || a[6:5] == 2'h2);
		if (op == 2'h0 && n == 5'h0A && a[6:5] == 2'h3)
			wen = 1;
		if (op == 2'h0 && n == 5'h0A && a[6:5] == 2'h0)
			wen = 0;
		if (wen && n != 0 && (op[0] || g)) begin
			for (int i = 0; i < 128; i++)
				if (g || i == a)
					mem[i] = (n == 5'h12) ? sh[7:0] : 8'hFF;
			pend = 1;
			cnt = dly_i;
		end
		n = 0;
	end
endmodule
`default_nettype wire

// ==== dv/sec_ctrl_checker.sv ====
// checker for sec_ctrl pin and flag timing
// assumes one clock domain, bound to sec_ctrl
`timescale 1ns/1ps
`default_nettype none
module sec_ctrl_checker (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic soft_reset_i,
	input wire logic host_cmd_wr_i,
	input wire logic host_busy_i,
	input wire logic nvm_if_disable_i,
	input wire logic mii_monitor_sel_i,
	input wire logic gp_clock_i,
	input wire logic mii_mon_clock_i,
	input wire logic nvm_clock_pin_o,
	input wire logic nvm_chip_select_o,
	input wire logic nvm_busy_flag_o,
	input wire logic nvm_timeout_flag_o,
	input wire logic station_addr_loaded_flag_o,
	input wire logic [2:0] nvm_opcode_field_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	wire en = !nvm_if_disable_i;
	logic sclk_q;
	logic [4:0] n_q;
	// counts serial clock rises inside one select frame
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclk_q <= 1'h0;
			n_q <= 5'h00;
		end else begin
			sclk_q <= nvm_clock_pin_o;
			if (!nvm_chip_select_o)
				n_q <= 5'h00;
			else if (nvm_clock_pin_o && !sclk_q)
				n_q <= n_q + 5'h01;
		end
	end
	sequence s_go;
		host_cmd_wr_i && host_busy_i && !nvm_busy_flag_o && !soft_reset_i;
	endsequence
	sequence s_high;
		nvm_clock_pin_o [*4] ##1 !nvm_clock_pin_o;
	endsequence
	property p_go;
		s_go |=> nvm_busy_flag_o && !nvm_timeout_flag_o;
	endproperty
	a_go: assert property (p_go) else $error("command not started");
	property p_refuse;
		host_cmd_wr_i && nvm_busy_flag_o |=> $stable(nvm_opcode_field_o);
	endproperty
	a_refuse: assert property (p_refuse) else $error("write taken while busy");
	property p_load;
		$rose(station_addr_loaded_flag_o) |-> $fell(nvm_busy_flag_o);
	endproperty
	a_load: assert property (p_load) else $error("loaded flag early");
	property p_tmo;
		$rose(nvm_timeout_flag_o) |-> $fell(nvm_busy_flag_o);
	endproperty
	a_tmo: assert property (p_tmo) else $error("timeout without end");
	property p_half;
		en && $rose(nvm_clock_pin_o) |-> s_high;
	endproperty
	a_half: assert property (p_half) else $error("serial clock width");
	property p_idle;
		en && $past(en) && !nvm_chip_select_o |-> !nvm_clock_pin_o;
	endproperty
	a_idle: assert property (p_idle) else $error("clock outside frame");
	property p_count;
		en && $fell(nvm_chip_select_o) |-> n_q == 5'h00 || n_q == 5'h0A || n_q == 5'h12;
	endproperty
	a_count: assert property (p_count) else $error("frame clock count");
	property p_mux;
		!en && $past(nvm_if_disable_i) |->
			nvm_clock_pin_o == ($past(mii_monitor_sel_i) ? $past(mii_mon_clock_i) : $past(gp_clock_i));
	endproperty
	a_mux: assert property (p_mux) else $error("clock pin reuse");
	property p_csoff;
		!en && $past(nvm_if_disable_i) |-> !nvm_chip_select_o;
	endproperty
	a_csoff: assert property (p_csoff) else $error("select while disabled");
endmodule
bind sec_ctrl sec_ctrl_checker i_chk (.clk_i, .resetn_i, .soft_reset_i, .host_cmd_wr_i, .host_busy_i,
	.nvm_if_disable_i, .mii_monitor_sel_i, .gp_clock_i, .mii_mon_clock_i, .nvm_clock_pin_o,
	.nvm_chip_select_o, .nvm_busy_flag_o, .nvm_timeout_flag_o, .station_addr_loaded_flag_o, .nvm_opcode_field_o);
`default_nettype wire

// ==== dv/sec_ctrl_bench.sv ====
// self-checking bench for sec_ctrl with a serial memory model
// assumes sec_defs.vh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "sec_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("wrong value at %0t: %h not %h", $time, g, e); end end
module sec_ctrl_bench;
	logic clk_i = 0, resetn_i = 0, soft_reset_i = 0, host_cmd_wr_i = 0, host_busy_i = 0, host_data_wr_i = 0;
	logic host_station_wr_i = 0, nvm_if_disable_i = 0, mii_monitor_sel_i = 0, gp_data_i = 0, gp_clock_i = 0;
	logic mii_mon_data_i = 0, mii_mon_clock_i = 0, stall = 0;
	logic [2:0] host_opcode_i = 0;
	logic [6:0] host_location_i = 0, a;
	logic [7:0] host_data_i = 0, dly = 0, d;
	logic [47:0] host_station_i = 0, s;
	logic [7:0] sh [128];
	int err_total = 0, cmp_count = 0;
	wire nvm_serial_data_pin_i, nvm_serial_data_pin_o, nvm_serial_data_pin_oe_o, nvm_clock_pin_o, m_do;
	wire nvm_chip_select_o, nvm_busy_flag_o, nvm_timeout_flag_o, station_addr_loaded_flag_o;
	wire [2:0] nvm_opcode_field_o;
	wire [6:0] nvm_location_field_o;
	wire [7:0] nvm_data_reg_o;
	wire [31:0] station_addr_low_reg_o;
	wire [15:0] station_addr_high_reg_o;
	wire [47:0] st = {station_addr_high_reg_o, station_addr_low_reg_o};
	assign nvm_serial_data_pin_i = nvm_serial_data_pin_oe_o ? nvm_serial_data_pin_o : m_do;
	always #25 clk_i = ~clk_i;
	sec_ctrl #(.TIMEOUT_CYCLES(200), .SCLK_HALF(4)) i_dut (.clk_i, .resetn_i, .soft_reset_i, .host_cmd_wr_i,
		.host_busy_i, .host_opcode_i, .host_location_i, .host_data_wr_i, .host_data_i, .host_station_wr_i,
		.host_station_i, .nvm_if_disable_i, .mii_monitor_sel_i, .gp_data_i, .gp_clock_i, .mii_mon_data_i,
		.mii_mon_clock_i, .nvm_serial_data_pin_i, .nvm_serial_data_pin_o, .nvm_serial_data_pin_oe_o,
		.nvm_clock_pin_o, .nvm_chip_select_o, .nvm_busy_flag_o, .nvm_timeout_flag_o, .station_addr_loaded_flag_o,
		.nvm_opcode_field_o, .nvm_location_field_o, .nvm_data_reg_o, .station_addr_low_reg_o,
		.station_addr_high_reg_o);
	sec_nvm_model i_mem (.clk_i, .cs_i(nvm_chip_select_o), .sclk_i(nvm_clock_pin_o),
		.di_i(nvm_serial_data_pin_i), .stall_i(stall), .dly_i(dly), .do_o(m_do));
	function automatic logic [47:0] stn();
		for (int k = 0; k < 6; k++)
			stn[8 * k +: 8] = sh[k + 1];
	endfunction
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic idle();
		int i;
		i = 0;
		do begin
			@(posedge clk_i);
			#1;
			i++;
		end while (nvm_busy_flag_o !== 1'h0 && i < 4000);
		`CHK(i < 4000, 1'h1)
	endtask
	task automatic op(input logic [2:0] c, input logic [6:0] l, input logic [7:0] v);
		@(posedge clk_i);
		host_data_i <= v;
		host_data_wr_i <= 1'h1;
		host_opcode_i <= c;
		host_location_i <= l;
		host_busy_i <= 1'h1;
		host_cmd_wr_i <= 1'h1;
		@(posedge clk_i);
		host_data_wr_i <= 1'h0;
		host_cmd_wr_i <= 1'h0;
		idle();
	endtask
	task automatic rd(input logic [6:0] l, input logic [7:0] e);
		op(`SEC_OP_READ, l, 8'h00);
		`CHK(nvm_data_reg_o, e)
		`CHK(nvm_location_field_o, l)
	endtask
	initial begin
		#5000000;
		err_total++;
		$display("watchdog expired");
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'hE70F));
		for (int i = 0; i < 128; i++) begin
			sh[i] = (i == 0) ? 8'hA5 : 8'($urandom);
			i_mem.mem[i] = sh[i];
		end
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'h1;
		op(`SEC_OP_WR_ENABLE, 7'h00, 8'h00);
		`CHK(nvm_opcode_field_o, 3'h0)
		`CHK(station_addr_loaded_flag_o, 1'h1)
		`CHK(st, stn())
		$display("test auto-load done");
		a = 7'($urandom);
		op(`SEC_OP_WRITE, a, ~sh[a]);
		rd(a, sh[a]);
		op(`SEC_OP_WR_ENABLE, 7'h00, 8'h00);
		for (int k = 0; k < 6; k++) begin
			a = (k == 0) ? 7'h00 : (k == 1) ? 7'h7F : 7'($urandom);
			sh[a] = 8'($urandom);
			dly = 8'($urandom % 150);
			op(`SEC_OP_WRITE, a, sh[a]);
			`CHK(nvm_timeout_flag_o, 1'h0)
			rd(a, sh[a]);
		end
		a = 7'($urandom);
		op(`SEC_OP_ERASE, a, 8'h00);
		rd(a, 8'hFF);
		d = 8'($urandom);
		op(`SEC_OP_WRITE_ALL, 7'h00, d);
		rd(7'($urandom), d);
		op(`SEC_OP_ERASE_ALL, 7'h00, 8'h00);
		rd(7'($urandom), 8'hFF);
		op(`SEC_OP_WR_DISABLE, 7'h00, 8'h00);
		op(`SEC_OP_WRITE, 7'h05, 8'h3C);
		rd(7'h05, 8'hFF);
		$display("test host operations done");
		for (int i = 0; i < 128; i++)
			sh[i] = 8'hFF;
		op(`SEC_OP_WR_ENABLE, 7'h00, 8'h00);
		stall = 1'h1;
		op(`SEC_OP_WRITE, 7'h01, 8'h11);
		`CHK(nvm_timeout_flag_o, 1'h1)
		stall = 1'h0;
		sh[1] = 8'h11;
		rd(7'h01, 8'h11);
		`CHK(nvm_timeout_flag_o, 1'h0)
		$display("test timeout done");
		s = 48'({$urandom, $urandom});
		@(posedge clk_i);
		host_station_i <= s;
		host_station_wr_i <= 1'h1;
		@(posedge clk_i);
		host_station_wr_i <= 1'h0;
		op(`SEC_OP_RELOAD, 7'h00, 8'h00);
		`CHK(station_addr_loaded_flag_o, 1'h0)
		`CHK(st, s)
		op(`SEC_OP_WRITE, 7'h00, 8'hA5);
		op(`SEC_OP_RELOAD, 7'h00, 8'h00);
		`CHK(station_addr_loaded_flag_o, 1'h1)
		`CHK(st, stn())
		sh[6] = 8'($urandom);
		op(`SEC_OP_WRITE, 7'h06, sh[6]);
		@(posedge clk_i);
		soft_reset_i <= 1'h1;
		@(posedge clk_i);
		soft_reset_i <= 1'h0;
		for (int i = 0; i < 8 && nvm_busy_flag_o !== 1'h1; i++)
			@(posedge clk_i);
		idle();
		`CHK(st, stn())
		$display("test reload done");
		for (int k = 0; k < 32; k++) begin
			@(posedge clk_i);
			nvm_if_disable_i <= 1'h1;
			{mii_monitor_sel_i, gp_data_i, mii_mon_data_i, mii_mon_clock_i} <= 4'($urandom);
			gp_clock_i <= k[1];
			@(posedge clk_i);
			@(negedge clk_i);
			`CHK(nvm_serial_data_pin_o, mii_monitor_sel_i ? mii_mon_data_i : gp_data_i)
			`CHK(nvm_serial_data_pin_oe_o, 1'h1)
		end
		$display("test pin reuse done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
